//--- bus_phase_pkg.sv
package bus_phase_pkg;

  // ----------------------------------------------------------------
  // Phase timing in bus clocks after the request strobe
  // ----------------------------------------------------------------
  localparam int unsigned ERROR_PHASE_DELAY = 3;
  localparam int unsigned SNOOP_PHASE_DELAY = 4;
  localparam int unsigned SNOOP_SPACING = 3;
  localparam int unsigned STALL_RESAMPLE = 2;
  localparam int unsigned RETRY_LIMIT = 1;
  localparam int unsigned QUEUE_DEPTH = 8;
  localparam int unsigned QPTR_W = 3;
  localparam logic [2:0] DLY_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Address parity coverage and address space codes
  // ----------------------------------------------------------------
  localparam int unsigned UPPER_HI = 35;
  localparam int unsigned UPPER_LO = 24;
  localparam int unsigned LOWER_HI = 23;
  localparam int unsigned LOWER_LO = 3;
  localparam logic [1:0] ASZ_32BIT = 2'h0;
  localparam logic [1:0] ASZ_36BIT = 2'h1;

  // ----------------------------------------------------------------
  // Response status codes, logical (asserted = 1)
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RESP_IDLE = 3'h0,
    RESP_RETRY = 3'h1,
    RESP_DEFERRED = 3'h2,
    RESP_RESERVED = 3'h3,
    RESP_HARD_FAIL = 3'h4,
    RESP_NO_DATA = 3'h5,
    RESP_IMPLICIT_WB = 3'h6,
    RESP_NORMAL = 3'h7
  } resp_e;

  // Request as observed on the bus; all fields are logical levels.
  typedef struct packed {
    logic request_strobe;
    logic [35:3] address;
    logic [4:0] req_type;
    logic [1:0] address_space_size;
    logic [1:0] address_parity_bits;
    logic request_parity;
    logic is_memory;
    logic is_write;
    logic has_data;
    logic own_request;
    logic addressed_to_us;
  } bus_req_s;

  // Local snoop answer from the cache.
  typedef struct packed {
    logic ready;
    logic hit;
    logic modified;
    logic defer;
  } snoop_ans_s;

  // Snoop wires as sampled from the bus (wired-OR of all agents).
  typedef struct packed {
    logic shared_hit;
    logic snoop_dirty_flag;
    logic postpone;
  } snoop_bus_s;

  typedef struct packed {
    logic is_write;
    logic has_data;
    logic ours;
    logic dirty;
    logic postponed;
  } ioq_entry_s;

  localparam int unsigned RESP_CODE_W = 3;
endpackage

//--- parity_checker.sv
`timescale 1ns/1ps
`default_nettype none

// Checks request and address parity of one request. Inputs are logical
// levels; an asserted low-true pin is electrically low, so an even count
// of low levels equals an even count of asserted bits.
module parity_checker (
  input wire logic [35:3] address_i,
  input wire logic [4:0] req_type_i,
  input wire logic request_strobe_i,
  input wire logic [1:0] address_parity_bits_i,
  input wire logic request_parity_i,
  output logic upper_error_o,
  output logic lower_error_o,
  output logic request_error_o
);
  always_comb begin
    upper_error_o = ^{address_i[bus_phase_pkg::UPPER_HI:bus_phase_pkg::UPPER_LO],
                      address_parity_bits_i[1]}; // [R23]
    lower_error_o = ^{address_i[bus_phase_pkg::LOWER_HI:bus_phase_pkg::LOWER_LO],
                      address_parity_bits_i[0]}; // [R23]
    request_error_o = ^{req_type_i, request_strobe_i, request_parity_i}; // [R24]
  end
endmodule

`default_nettype wire

//--- bus_phase_agent.sv
// Summary of operation
// R01: Error phase one clock, three after strobe.
// R02: Drivers all disabled: ignore parity errors.
// R03: Check parity, assert error in error phase.
// R04: No upper error outside own address range.
// R05: Observation enabled: sampled error cancels request.
// R06: Retry cancelled request once, then hard error.
// R07: Cancelled transaction leaves queue, snoops ignored.
// R08: Cancellation resets rotating arbitration identifier.
// R09: Snoop four after strobe, three after previous. Code: no snoop in the clock after an error phase if one snooped entry waits.
// R10: Caching agents drive hit flags on memory requests.
// R11: Keep line: shared hit, dirty deasserted.
// R12: Shared hit limits requester to Shared.
// R13: Modified holder asserts dirty flag, writes back.
// R14: Memory agent takes writeback on dirty flag. Code: accepts it only on writes; a read with dirty flag gets no accept.
// R15: Both hits means stall; resample two later.
// R16: Postpone needs deferred, retry or hard error.
// R17: Dirty flag overrides postpone for response.
// R18: Response after own snoop, previous response, data.
// R19: Every agent keeps in-order queue; target responds.
// R20: Write accept once, twice with writeback.
// R21: Three-bit status, back to idle after sampling.
// R22: Response parity valid always, even low count.
// R23: Upper parity 35..24, lower 23..3.
// R24: Request parity covers type lines and strobe.
// R25: Driver and observation enables captured at configuration.
`timescale 1ns/1ps
`default_nettype none

module bus_phase_agent (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic config_latch_i,
  input wire logic cfg_error_drive_i,
  input wire logic cfg_error_observe_i,
  input wire logic cfg_wide_address_i,
  input wire bus_phase_pkg::bus_req_s req_i,
  input wire logic address_parity_error_i,
  input wire bus_phase_pkg::snoop_ans_s snoop_ans_i,
  input wire bus_phase_pkg::snoop_bus_s snoop_bus_i,
  input wire logic data_done_i,
  input wire logic write_data_taken_i,
  input wire logic resp_ready_i,
  input wire logic [2:0] resp_code_i,
  output logic address_parity_error_o,
  output logic [1:0] snoop_drive_o,
  output logic postpone_o,
  output logic snoop_valid_o,
  output logic share_limit_o,
  output logic writeback_due_o,
  output logic target_write_accept_o,
  output logic [2:0] response_status_code_o,
  output logic response_status_parity_o,
  output logic resp_issued_o,
  output logic retry_request_o,
  output logic hard_error_o,
  output logic arb_id_reset_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RSP_WAIT, RSP_ACCEPT, RSP_ACCEPT_WB, RSP_DRIVE} rsp_e;

  typedef struct packed {
    logic drive_en;
    logic observe_en;
    logic [2:0] err_dly;
    logic err_pending;
    logic err_own;
    logic err_cancel;
    logic retried;
    logic [2:0] snoop_gap;
    logic snooping;
    logic [1:0] stall_cnt;
    logic [bus_phase_pkg::QPTR_W-1:0] rd_ptr;
    logic [bus_phase_pkg::QPTR_W-1:0] wr_ptr;
    logic [bus_phase_pkg::QPTR_W-1:0] snp_ptr;
    logic [bus_phase_pkg::QPTR_W:0] count;
    logic [bus_phase_pkg::QPTR_W:0] snooped;
    bus_phase_pkg::ioq_entry_s [bus_phase_pkg::QUEUE_DEPTH-1:0] ioq;
    logic [bus_phase_pkg::QUEUE_DEPTH-1:0][3:0] age;
    rsp_e rsp;
    logic [2:0] code;
    logic err_out;
    logic [1:0] hits;
    logic postpone;
    logic snoop_valid;
    logic share_limit;
    logic wb_due;
    logic accept;
    logic issued;
    logic retry_req;
    logic hard_err;
    logic arb_reset;
  } state_s;

  state_s st;
  state_s next_st;
  logic up_err;
  logic lo_err;
  logic rq_err;
  logic [2:0] strobe_hist;
  logic [2:0] next_strobe_hist;

  function automatic logic [bus_phase_pkg::QPTR_W-1:0] inc_ptr(
    input logic [bus_phase_pkg::QPTR_W-1:0] p);
    inc_ptr = p + 1'b1;
  endfunction

  parity_checker u_parity (
    .address_i(req_i.address),
    .req_type_i(req_i.req_type),
    .request_strobe_i(req_i.request_strobe),
    .address_parity_bits_i(req_i.address_parity_bits),
    .request_parity_i(req_i.request_parity),
    .upper_error_o(up_err),
    .lower_error_o(lo_err),
    .request_error_o(rq_err)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic upper_in_range;
    logic err_found;
    logic cancel;
    logic stall;
    logic snoop_now;
    bus_phase_pkg::ioq_entry_s head;
    upper_in_range = 1'b0;
    err_found = 1'b0;
    cancel = 1'b0;
    stall = 1'b0;
    snoop_now = 1'b0;
    head = st.ioq[st.rd_ptr];
    next_st = st;
    next_strobe_hist = {strobe_hist[1:0], req_i.request_strobe};
    next_st.err_out = 1'b0;
    next_st.issued = 1'b0;
    next_st.retry_req = 1'b0;
    next_st.hard_err = 1'b0;
    next_st.arb_reset = 1'b0;
    next_st.snoop_valid = 1'b0;
    next_st.accept = 1'b0;

    if (config_latch_i) begin
      next_st.drive_en = cfg_error_drive_i; // [R25]
      next_st.observe_en = cfg_error_observe_i; // [R25]
    end

    // Ages advance first so that a new strobe below always restarts its own slot.
    for (int i = 0; i < bus_phase_pkg::QUEUE_DEPTH; i++) begin
      if (st.age[i] != 4'hF) begin
        next_st.age[i] = st.age[i] + 4'h1;
      end
    end

    // Parity check in the strobe clock; result waits for the error phase.
    if (req_i.request_strobe) begin
      upper_in_range = !req_i.is_memory ||
                       req_i.address_space_size == bus_phase_pkg::ASZ_32BIT ||
                       (cfg_wide_address_i &&
                        req_i.address_space_size == bus_phase_pkg::ASZ_36BIT); // [R04]
      err_found = rq_err || lo_err || (up_err && upper_in_range); // [R03] [R23] [R24]
      next_st.err_pending = err_found && st.drive_en; // [R02]
      next_st.err_own = req_i.own_request;
      next_st.err_dly = 3'h1;
      next_st.ioq[st.wr_ptr] = '{req_i.is_write, req_i.has_data,
                                 req_i.addressed_to_us, 1'b0, 1'b0}; // [R19]
      next_st.age[st.wr_ptr] = 4'h1;
      next_st.wr_ptr = inc_ptr(st.wr_ptr);
      next_st.count = st.count + 1'b1;
    end else if (st.err_dly != bus_phase_pkg::DLY_RESET) begin
      next_st.err_dly = st.err_dly + 3'h1;
    end
    if (st.err_dly == 3'(bus_phase_pkg::ERROR_PHASE_DELAY - 1)) begin
      next_st.err_out = st.err_pending; // [R01]
      next_st.err_dly = bus_phase_pkg::DLY_RESET;
    end

    // Error phase sample: cancel the newest queue entry.
    if (strobe_hist[2] && st.observe_en && address_parity_error_i) begin // [R05]
      cancel = 1'b1;
      next_st.wr_ptr = st.wr_ptr - 1'b1; // [R07]
      next_st.count = next_st.count - 1'b1; // [R07]
      next_st.arb_reset = 1'b1; // [R08]
      if (st.err_own) begin
        next_st.retry_req = !st.retried; // [R06]
        next_st.hard_err = st.retried; // [R06]
        next_st.retried = !st.retried;
      end
    end else if (strobe_hist[2] && st.err_own) begin
      next_st.retried = 1'b0;
    end

    // Snoop phase: four after strobe and three after previous result, but never in the clock after an error phase while one snooped entry is queued.
    if (st.snoop_gap != 3'h0) begin
      next_st.snoop_gap = st.snoop_gap - 3'h1;
    end
    stall = snoop_bus_i.shared_hit && snoop_bus_i.snoop_dirty_flag;
    if (st.snooping) begin
      if (st.stall_cnt != 2'h0) begin
        next_st.stall_cnt = st.stall_cnt - 2'h1;
      end else if (stall) begin
        next_st.stall_cnt = 2'(bus_phase_pkg::STALL_RESAMPLE - 1); // [R15]
      end else begin
        next_st.snooping = 1'b0;
        next_st.hits = 2'h0;
        next_st.postpone = 1'b0;
        next_st.snoop_valid = 1'b1;
        next_st.share_limit = snoop_bus_i.shared_hit; // [R12]
        next_st.ioq[st.snp_ptr].dirty = snoop_bus_i.snoop_dirty_flag; // [R13]
        next_st.ioq[st.snp_ptr].postponed = snoop_bus_i.postpone;
        next_st.wb_due = snoop_ans_i.modified; // [R13]
        next_st.snp_ptr = inc_ptr(st.snp_ptr);
        next_st.snooped = st.snooped + 1'b1;
        next_st.snoop_gap = 3'(bus_phase_pkg::SNOOP_SPACING - 2); // [R09]
      end
    end
    snoop_now = !st.snooping && st.snoop_gap == 3'h0 && st.snooped < st.count &&
                st.age[st.snp_ptr] >= 4'(bus_phase_pkg::SNOOP_PHASE_DELAY - 1) &&
                !(strobe_hist[2] && st.snp_ptr == inc_ptr(st.rd_ptr)); // [R09]
    if (snoop_now && !cancel) begin // [R07]
      next_st.snooping = 1'b1;
      next_st.stall_cnt = 2'h0;
      next_st.hits[1] = snoop_ans_i.ready ? snoop_ans_i.hit && !snoop_ans_i.modified
                                          : 1'b1; // [R10] [R11] [R15]
      next_st.hits[0] = snoop_ans_i.ready ? snoop_ans_i.modified : 1'b1; // [R13] [R15]
      next_st.postpone = snoop_ans_i.ready && snoop_ans_i.defer;
    end else if (st.snooping && !snoop_ans_i.ready) begin
      next_st.hits = 2'h3; // [R15]
    end else if (st.snooping && st.stall_cnt == 2'h0 && stall) begin
      next_st.hits = {snoop_ans_i.hit && !snoop_ans_i.modified, snoop_ans_i.modified};
      next_st.postpone = snoop_ans_i.defer;
    end

    // Response phase for the head entry when we are its target.
    unique case (st.rsp)
      RSP_WAIT: begin
        // The head retires one clock after the issue pulse; wait so it is not answered twice.
        if (!st.issued && st.snooped != '0 && head.ours && resp_ready_i &&
            (!head.has_data || data_done_i)) begin // [R18]
          if (head.is_write) begin
            next_st.rsp = head.dirty ? RSP_ACCEPT_WB : RSP_ACCEPT;
            next_st.accept = 1'b1; // [R20]
          end else begin
            next_st.rsp = RSP_DRIVE;
          end
        end
      end
      RSP_ACCEPT_WB: begin
        if (write_data_taken_i) begin
          next_st.rsp = RSP_ACCEPT;
          next_st.accept = 1'b1; // [R20]
        end
      end
      RSP_ACCEPT: begin
        if (write_data_taken_i) begin
          next_st.rsp = RSP_DRIVE;
        end
      end
      RSP_DRIVE: begin
        if (st.code == bus_phase_pkg::RESP_IDLE) begin
          if (head.dirty) begin
            next_st.code = bus_phase_pkg::RESP_IMPLICIT_WB; // [R17]
          end else if (head.postponed) begin
            next_st.code = (resp_code_i == bus_phase_pkg::RESP_RETRY ||
                            resp_code_i == bus_phase_pkg::RESP_HARD_FAIL)
                           ? resp_code_i : bus_phase_pkg::RESP_DEFERRED; // [R16]
          end else begin
            next_st.code = resp_code_i; // [R21]
          end
        end else begin
          next_st.code = bus_phase_pkg::RESP_IDLE; // [R21]
          next_st.issued = 1'b1;
          next_st.rsp = RSP_WAIT;
        end
      end
    endcase

    // Retire the head after our issue pulse, or, for entries we do not answer, once data_done_i is seen.
    if (st.issued || (st.rsp == RSP_WAIT && st.snooped != '0 && !head.ours &&
                      data_done_i)) begin // [R19]
      next_st.rd_ptr = inc_ptr(st.rd_ptr);
      next_st.count = next_st.count - 1'b1;
      next_st.snooped = next_st.snooped - 1'b1;
      next_st.wb_due = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.rsp <= RSP_WAIT;
      strobe_hist <= 3'h0;
    end else if (clk_en_i) begin
      st <= next_st;
      strobe_hist <= next_strobe_hist;
    end
  end

  // Parity is computed on the driven levels so it stays valid on idle clocks.
  always_comb begin
    address_parity_error_o = st.err_out; // [R01] [R03]
    snoop_drive_o = st.hits;
    postpone_o = st.postpone;
    snoop_valid_o = st.snoop_valid;
    share_limit_o = st.share_limit;
    writeback_due_o = st.wb_due;
    target_write_accept_o = st.accept;
    response_status_code_o = st.code;
    response_status_parity_o = ^st.code; // [R22]
    resp_issued_o = st.issued;
    retry_request_o = st.retry_req;
    hard_error_o = st.hard_err;
    arb_id_reset_o = st.arb_reset;
  end
endmodule

`default_nettype wire

//--- bus_phase_chk.sv
`timescale 1ns/1ps
`default_nettype none

module bus_phase_chk (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic config_latch_i,
  input wire logic cfg_error_drive_i,
  input wire logic cfg_wide_address_i,
  input wire bus_phase_pkg::bus_req_s req_i,
  input wire logic address_parity_error_i,
  input wire logic address_parity_error_o,
  input wire logic [2:0] response_status_code_o,
  input wire logic response_status_parity_o,
  input wire logic arb_id_reset_o
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic drv;
  logic hard_bad;
  logic upper_bad;
  logic in_range;
  logic upper_out;

  // Mirrors the captured driver enable so the checks follow configuration.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      drv <= 1'b0;
    end else if (config_latch_i) begin
      drv <= cfg_error_drive_i;
    end
  end

  assign hard_bad = req_i.request_strobe &&
    ((^{req_i.address[23:3], req_i.address_parity_bits[0]}) ||
     (^{req_i.req_type, req_i.request_strobe, req_i.request_parity}));
  assign upper_bad = ^{req_i.address[35:24], req_i.address_parity_bits[1]};
  assign in_range = (req_i.address_space_size == bus_phase_pkg::ASZ_32BIT) ||
    (cfg_wide_address_i && req_i.address_space_size == bus_phase_pkg::ASZ_36BIT);
  assign upper_out = req_i.request_strobe && req_i.is_memory && upper_bad && !in_range;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  err_one_clock_a: assert property (address_parity_error_o |=> !address_parity_error_o)
    else $error("parity error output lasted more than one clock");
  err_phase_slot_a: assert property (address_parity_error_o |->
    $past(req_i.request_strobe, 3))
    else $error("parity error output outside the error phase");
  err_detect_a: assert property ($past(hard_bad, 3) && drv |-> address_parity_error_o)
    else $error("parity mismatch not flagged in the error phase");
  err_disabled_a: assert property (address_parity_error_o |-> drv)
    else $error("parity error driven while the driver is disabled");
  upper_range_a: assert property ($past(upper_out, 3) && !$past(hard_bad, 3)
    |-> !address_parity_error_o)
    else $error("upper parity error flagged outside own address range");
  arb_reset_a: assert property (arb_id_reset_o |->
    $past(address_parity_error_i) || $past(address_parity_error_i, 2))
    else $error("arbitration reset without a sampled parity error");
  code_idle_a: assert property (response_status_code_o != bus_phase_pkg::RESP_IDLE
    |=> response_status_code_o == bus_phase_pkg::RESP_IDLE)
    else $error("response code not returned to idle");
  resp_parity_a: assert property (response_status_parity_o == ^response_status_code_o)
    else $error("response parity wrong");

  cover property (address_parity_error_o);
  cover property (arb_id_reset_o);
  cover property (response_status_code_o == bus_phase_pkg::RESP_NORMAL);
endmodule

bind bus_phase_agent bus_phase_chk i_chk (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .config_latch_i(config_latch_i),
  .cfg_error_drive_i(cfg_error_drive_i),
  .cfg_wide_address_i(cfg_wide_address_i),
  .req_i(req_i),
  .address_parity_error_i(address_parity_error_i),
  .address_parity_error_o(address_parity_error_o),
  .response_status_code_o(response_status_code_o),
  .response_status_parity_o(response_status_parity_o),
  .arb_id_reset_o(arb_id_reset_o)
);

`default_nettype wire

//--- bus_agents_model.sv
`timescale 1ns/1ps
`default_nettype none

module bus_agents_model (
  input wire logic sys_clk_i,
  input wire logic address_parity_error_o,
  input wire logic [1:0] snoop_drive_o,
  input wire logic postpone_o,
  input wire logic target_write_accept_o,
  output var bus_phase_pkg::bus_req_s req_i,
  output wire logic address_parity_error_i,
  output wire bus_phase_pkg::snoop_bus_s snoop_bus_i,
  output var logic write_data_taken_i
);
  logic inject = 1'b0;

  initial req_i = '0;
  initial write_data_taken_i = 1'b0;

  // The parity error line is wired-OR of this agent and the other agents; the snoop lines carry this agent's drive only.
  assign address_parity_error_i = address_parity_error_o | inject;
  assign snoop_bus_i = {snoop_drive_o[1], snoop_drive_o[0], postpone_o};

  // The target side takes each write transfer one clock after the accept.
  always @(posedge sys_clk_i) begin
    write_data_taken_i <= target_write_accept_o;
  end

  task automatic issue(input logic [35:3] a, input logic [1:0] asz, input logic [2:0] bad,
      input logic own, input logic wr);
    bus_phase_pkg::bus_req_s r;
    r = '0;
    r.request_strobe = 1'b1;
    r.address = a;
    r.req_type = {asz, 2'h3, wr};
    r.address_space_size = asz;
    r.address_parity_bits = {(^a[35:24]) ^ bad[1], (^a[23:3]) ^ bad[0]};
    r.request_parity = (^{r.req_type, 1'b1}) ^ bad[2];
    r.is_memory = 1'b1;
    r.is_write = wr;
    r.has_data = 1'b1;
    r.own_request = own;
    r.addressed_to_us = 1'b1;
    @(posedge sys_clk_i);
    req_i <= r;
    r.request_strobe = 1'b0;
    @(posedge sys_clk_i);
    req_i <= r;
    r = ~r;
    r.request_strobe = 1'b0;
    @(posedge sys_clk_i);
    req_i <= r;
  endtask
endmodule

`default_nettype wire

//--- tb_bus_error_snoop_response_phases.sv
`timescale 1ns/1ps
`default_nettype none

module tb_bus_error_snoop_response_phases;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic config_latch_i = 1'b0;
  logic cfg_error_drive_i = 1'b0;
  logic cfg_error_observe_i = 1'b0;
  logic cfg_wide_address_i = 1'b0;
  bus_phase_pkg::snoop_ans_s snoop_ans_i = '0;
  logic [2:0] resp_code_i = 3'h0;
  bus_phase_pkg::bus_req_s req_i;
  bus_phase_pkg::snoop_bus_s snoop_bus_i;
  logic address_parity_error_i, write_data_taken_i, address_parity_error_o, postpone_o;
  logic target_write_accept_o, response_status_parity_o, resp_issued_o;
  logic retry_request_o, hard_error_o, arb_id_reset_o, share_limit_o;
  logic [1:0] snoop_drive_o;
  logic [2:0] response_status_code_o;
  logic [2:0] last_code = 3'h0;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  int n_arb = 0, n_iss = 0, n_acc = 0, n_retry = 0, n_hard = 0;
  int e_arb = 0, e_iss = 0, e_acc = 0, e_retry = 0, e_hard = 0, own_fails = 0;

  bus_phase_agent i_dut (
    .sys_clk_i, .rst_i, .clk_en_i(1'b1), .config_latch_i, .cfg_error_drive_i,
    .cfg_error_observe_i, .cfg_wide_address_i, .req_i, .address_parity_error_i,
    .snoop_ans_i, .snoop_bus_i, .data_done_i(1'b1), .write_data_taken_i,
    .resp_ready_i(1'b1), .resp_code_i, .address_parity_error_o, .snoop_drive_o,
    .postpone_o, .snoop_valid_o(), .share_limit_o, .writeback_due_o(),
    .target_write_accept_o, .response_status_code_o, .response_status_parity_o,
    .resp_issued_o, .retry_request_o, .hard_error_o, .arb_id_reset_o
  );

  bus_agents_model i_agents (
    .sys_clk_i, .address_parity_error_o, .snoop_drive_o, .postpone_o,
    .target_write_accept_o, .req_i, .address_parity_error_i, .snoop_bus_i,
    .write_data_taken_i
  );

  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------------------------------
  // Monitor and timeout
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    cycles++;
    if (response_status_code_o !== bus_phase_pkg::RESP_IDLE) last_code = response_status_code_o;
    if (arb_id_reset_o === 1'b1) n_arb++;
    if (resp_issued_o === 1'b1) n_iss++;
    if (target_write_accept_o === 1'b1) n_acc++;
    if (retry_request_o === 1'b1) n_retry++;
    if (hard_error_o === 1'b1) n_hard++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic set_cfg(input logic drv, input logic obs);
    @(posedge sys_clk_i);
    cfg_error_drive_i <= drv;
    cfg_error_observe_i <= obs;
    config_latch_i <= 1'b1;
    @(posedge sys_clk_i);
    config_latch_i <= 1'b0;
  endtask

  task automatic run_req(input logic [1:0] asz, input logic [2:0] bad, input logic own,
      input logic wr, input logic inj);
    logic exp_err;
    logic cancel;
    logic [2:0] exp_snp;
    int k;
    exp_err = cfg_error_drive_i && (bad[0] || bad[2] || (bad[1] &&
      (asz == 2'h0 || (cfg_wide_address_i && asz == 2'h1))));
    cancel = cfg_error_observe_i && (exp_err || inj);
    if (cancel) e_arb++;
    else e_iss++;
    if (!cancel && wr) e_acc++;
    if (own && cancel) own_fails++;
    if (own && cancel && own_fails == 1) e_retry++;
    if (own && cancel && own_fails > 1) e_hard++;
    snoop_ans_i <= '{ready: 1'b1, hit: 1'($urandom), modified: 1'b0, defer: 1'b0};
    resp_code_i <= wr ? bus_phase_pkg::RESP_NO_DATA : bus_phase_pkg::RESP_NORMAL;
    i_agents.issue({1'($urandom), $urandom}, asz, bad, own, wr);
    @(posedge sys_clk_i);
    i_agents.inject <= inj;
    #1;
    chk("error phase", 32'(exp_err), 32'(address_parity_error_o));
    @(posedge sys_clk_i);
    i_agents.inject <= 1'b0;
    exp_snp = {!cancel && snoop_ans_i.hit, 2'h0};
    #1;
    chk("snoop result", 32'(exp_snp), 32'({snoop_drive_o, postpone_o}));
    k = 0;
    while ((n_iss < e_iss || n_arb < e_arb) && k < 40) begin
      @(posedge sys_clk_i);
      k++;
    end
    repeat (2) @(posedge sys_clk_i);
    if (!cancel) chk("response code", 32'(resp_code_i), 32'(last_code));
    if (!cancel) chk("share limit", 32'(snoop_ans_i.hit), 32'(share_limit_o));
  endtask

  task automatic end_test(input string name);
    chk("cancellations", e_arb, n_arb);
    chk("responses", e_iss, n_iss);
    chk("write accepts", e_acc, n_acc);
    chk("retries", e_retry, n_retry);
    chk("hard errors", e_hard, n_hard);
    $display("test %s done", name);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(15528));
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    set_cfg(1'b1, 1'b1);
    for (int w = 0; w < 2; w++) begin
      for (int b = 0; b < 16; b++) begin
        cfg_wide_address_i <= w[0];
        @(posedge sys_clk_i);
        run_req(2'(b[3]), 3'(b), 1'b0, 1'b0, 1'b0);
      end
    end
    end_test("parity errors");
    set_cfg(1'b0, 1'b1);
    for (int b = 0; b < 8; b++) run_req(2'h0, 3'(b), 1'b0, 1'b0, b[0]);
    end_test("driver disabled");
    set_cfg(1'b1, 1'b1);
    run_req(2'h0, 3'h0, 1'b1, 1'b1, 1'b0);
    run_req(2'h0, 3'h1, 1'b1, 1'b0, 1'b0);
    run_req(2'h0, 3'h1, 1'b1, 1'b0, 1'b0);
    end_test("own retry");
    set_cfg(1'b1, 1'b0);
    run_req(2'h0, 3'h1, 1'b0, 1'b0, 1'b0);
    end_test("observation off");
    complete_run();
  end
endmodule

`default_nettype wire
